// *** rtl/spi_master_slave_port.sv ***
// Four-line SPI master/slave port with a classic Wishbone register slave.
//
// Overview of operation
// - Three-bit mode field picks SPI master or slave; the I2C code leaves the port off.
// - Full duplex, master or slave role.
// - Master starts transfers and drives serial clock.
// - Lines: data in, data out, clock, select.
// - Enable bit gates function, settings are kept.
// - Select enable off leaves select pin floating.
// - One eight-bit data register for both directions.
// - Bit order selectable, LSB or MSB first.
// - Capture on rising or falling clock edge.
// - Mode and format registers hold the controls.
// - Pins are assigned by outside pin sharing.
// - Mode codes pick clock source or slave.
// - Master data write starts one byte exchange.
// - Complete flag sets, stays until software clears.
// - Write while busy ignored, sets collision flag.
`timescale 1ns/1ps
module spi_master_slave_port
    import spi_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    input  wire logic              we_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic              stb_i,
    input  wire logic              cyc_i,
    output logic                   ack_o,
    input  wire logic              sck_i,
    output logic                   sck_o,
    output logic                   sck_oe_o,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe_o,
    input  wire logic              scs_n_i,
    output logic                   scs_n_o,
    output logic                   scs_n_oe_o,
    input  wire logic              sub_clk_i,
    input  wire logic              tmr_match_i,
    output logic                   irq_o
);

    generate
        if (ADDR_W < 6)
        begin : g_addr_check
            $error("ADDR_W must be at least 6.");
        end
    endgenerate

    logic [7:0] mode_reg;
    logic [7:0] format_reg;
    logic [7:0] data_reg;
    logic       trf_reg;
    logic       write_collision_flag_reg;
    logic       icf_reg;
    logic [2:0] int_status_reg;
    logic [2:0] int_mask_reg;
    logic       busy_reg;
    logic [4:0] edge_cnt_reg;
    logic [3:0] bit_cnt_reg;
    logic [4:0] div_cnt_reg;
    logic [3:0] pins_prev_reg;
    logic [3:0] pins_s;
    logic [7:0] rdata;

    // Pins from outside pass the three-stage synchroniser.
    pin_sync3 #(
        .W    (4),
        .INIT (4'h6)
    ) u_sync (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .pin_i    ({sub_clk_i, scs_n_i, sck_i, sdi_i}),
        .stable_o (pins_s)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pins_prev_reg <= 4'h6;
        end
        else
        begin
            pins_prev_reg <= pins_s;
        end
    end

    wire logic       sdi_s     = pins_s[0];
    wire logic       sck_rise  = pins_s[1] & ~pins_prev_reg[1];
    wire logic       sck_fall  = ~pins_s[1] & pins_prev_reg[1];
    wire logic       scs_rise  = pins_s[2] & ~pins_prev_reg[2];
    wire logic       sub_edge  = pins_s[3] ^ pins_prev_reg[3];
    wire logic [2:0] op_mode_field = mode_reg[MODE_MSB:MODE_LSB];
    wire logic       module_enable = mode_reg[EN_BIT];
    wire logic       clock_idle_level  = format_reg[POL_BIT];
    wire logic       clock_edge_sel    = format_reg[EDGE_BIT];
    wire logic       bit_order_sel     = format_reg[ORDER_BIT];
    wire logic       select_pin_enable = format_reg[SELECT_PIN_ENABLE_BIT];

    port_role_t role;
    always_comb
    begin
        role = PORT_OFF;
        if (module_enable)
        begin
            if (op_mode_field <= MODE_M_TMR)
            begin
                role = PORT_MASTER;
            end
            else if (op_mode_field == MODE_SLAVE)
            begin
                role = PORT_SLAVE;
            end
        end
    end

    wire logic is_master   = (role == PORT_MASTER);
    wire logic is_slave    = (role == PORT_SLAVE);
    wire logic idle_level  = ~clock_idle_level;
    wire logic cap_rising  = (clock_idle_level == clock_edge_sel);
    wire logic slave_sel   = ~select_pin_enable | ~pins_s[2];
    wire logic busy_any    = busy_reg | (bit_cnt_reg != 4'h0);

    // Master bit clock: half-period ticks from the chosen source.
    logic half_tick;
    always_comb
    begin
        case (op_mode_field)
            MODE_M_DIV4:  half_tick = (div_cnt_reg == HALF_DIV4);
            MODE_M_DIV16: half_tick = (div_cnt_reg == HALF_DIV16);
            MODE_M_DIV64: half_tick = (div_cnt_reg == HALF_DIV64);
            MODE_M_SUB:   half_tick = sub_edge;
            MODE_M_TMR:   half_tick = tmr_match_i;
            default:      half_tick = 1'b0;
        endcase
    end

    // Select falls one half period ahead of the first clock edge.
    wire logic m_edge  = busy_reg & half_tick & ~scs_n_o;
    wire logic m_cap   = m_edge & (~sck_o == cap_rising);
    wire logic m_shf   = m_edge & (~sck_o != cap_rising);
    wire logic s_act   = is_slave & slave_sel;
    wire logic s_cap   = s_act & (cap_rising ? sck_rise : sck_fall);
    wire logic s_shf   = s_act & (cap_rising ? sck_fall : sck_rise);
    wire logic cap     = m_cap | s_cap;
    wire logic shf     = m_shf | s_shf;
    wire logic m_done  = m_edge & (edge_cnt_reg == MASTER_LAST_EDGE);
    wire logic s_done  = s_cap & (bit_cnt_reg == SLAVE_LAST_BIT);
    wire logic s_abort = is_slave & select_pin_enable & scs_rise & (bit_cnt_reg != 4'h0);

    // Wishbone decode: one request per handshake, answer one cycle later.
    wire logic req     = cyc_i & stb_i & ~ack_o;
    wire logic wr      = req & we_i & sel_i[0];
    wire logic hi_zero = (adr_i[ADDR_W-1:5] == '0);
    wire logic [7:0] wd = dat_i[7:0];
    wire logic wr_mode = wr & hi_zero & (adr_i[4:0] == OFF_MODE_CTRL);
    wire logic wr_fmt  = wr & hi_zero & (adr_i[4:0] == OFF_FORMAT);
    wire logic wr_data = wr & hi_zero & (adr_i[4:0] == OFF_DATA);
    wire logic wr_sts  = wr & hi_zero & (adr_i[4:0] == OFF_INT_STATUS);
    wire logic wr_mask = wr & hi_zero & (adr_i[4:0] == OFF_INT_MASK);
    wire logic wr_ok   = wr_data & ~busy_any;
    wire logic collide = wr_data & busy_any;
    wire logic done    = m_done | s_done | s_abort;

    function automatic logic out_bit(input logic [7:0] v, input logic msb_first);
        out_bit = msb_first ? v[7] : v[0];
    endfunction : out_bit

    always_comb
    begin
        rdata = 8'h00;
        if (hi_zero)
        begin
            case (adr_i[4:0])
                OFF_MODE_CTRL:  rdata = {mode_reg[7:5], 1'b0, mode_reg[3:1], icf_reg};
                OFF_FORMAT:     rdata = {format_reg[7:2], write_collision_flag_reg, trf_reg};
                OFF_DATA:       rdata = data_reg;
                OFF_INT_STATUS: rdata = {5'h00, int_status_reg};
                OFF_INT_MASK:   rdata = {5'h00, int_mask_reg};
                default:        rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= req;
            if (req)
            begin
                dat_o <= {24'h00_0000, rdata};
            end
        end
    end

    // Control registers keep their values while the port is disabled.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg   <= MODE_CTRL_RESET;
            format_reg <= FORMAT_RESET;
        end
        else
        begin
            if (wr_mode)
            begin
                mode_reg <= {wd[7:5], 1'b0, wd[3:1], 1'b0};
            end
            if (wr_fmt)
            begin
                format_reg <= {wd[7:2], 2'b00};
            end
        end
    end

    // Status flags: a hardware set wins over a software write.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trf_reg  <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            icf_reg  <= 1'b0;
        end
        else
        begin
            trf_reg  <= done | (wr_fmt ? wd[TRF_BIT] : trf_reg);
            write_collision_flag_reg <= collide | (wr_fmt ? wd[WRITE_COLLISION_FLAG_BIT] : write_collision_flag_reg);
            icf_reg  <= s_abort | (wr_mode ? wd[ICF_BIT] : icf_reg);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            int_status_reg <= 3'h0;
            int_mask_reg   <= 3'h0;
            irq_o          <= 1'b0;
        end
        else
        begin
            int_status_reg[IRQ_DONE_BIT] <= done |
                (int_status_reg[IRQ_DONE_BIT] & ~(wr_sts & wd[IRQ_DONE_BIT]));
            int_status_reg[IRQ_WRITE_COLLISION_FLAG_BIT] <= collide |
                (int_status_reg[IRQ_WRITE_COLLISION_FLAG_BIT] & ~(wr_sts & wd[IRQ_WRITE_COLLISION_FLAG_BIT]));
            int_status_reg[IRQ_ICF_BIT]  <= s_abort |
                (int_status_reg[IRQ_ICF_BIT] & ~(wr_sts & wd[IRQ_ICF_BIT]));
            if (wr_mask)
            begin
                int_mask_reg <= wd[2:0];
            end
            irq_o <= |(int_status_reg & int_mask_reg);
        end
    end

    // The data register is also the shift register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_reg <= DATA_RESET;
        end
        else if (wr_ok)
        begin
            data_reg <= wd;
        end
        else if (cap)
        begin
            data_reg <= bit_order_sel ? {data_reg[6:0], sdi_s}
                                      : {sdi_s, data_reg[7:1]};
        end
    end

    // Master transfer sequencing.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_reg     <= 1'b0;
            edge_cnt_reg <= 5'h00;
            div_cnt_reg  <= 5'h00;
        end
        else if (!is_master)
        begin
            busy_reg     <= 1'b0;
            edge_cnt_reg <= 5'h00;
            div_cnt_reg  <= 5'h00;
        end
        else
        begin
            if (wr_ok)
            begin
                busy_reg     <= 1'b1;
                edge_cnt_reg <= 5'h00;
            end
            else if (m_done)
            begin
                busy_reg <= 1'b0;
            end
            else if (m_edge)
            begin
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
            end
            if (!busy_reg || half_tick)
            begin
                div_cnt_reg <= 5'h00;
            end
            else
            begin
                div_cnt_reg <= div_cnt_reg + 5'h01;
            end
        end
    end

    // Slave bit counting; select release mid-byte aborts the byte.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bit_cnt_reg <= 4'h0;
        end
        else if (!is_slave || !slave_sel || s_done || s_abort)
        begin
            bit_cnt_reg <= 4'h0;
        end
        else if (s_cap)
        begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // Pin drivers; a slave never drives the clock.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sck_o      <= 1'b1;
            sck_oe_o   <= 1'b0;
            sdo_o      <= 1'b0;
            sdo_oe_o   <= 1'b0;
            scs_n_o    <= 1'b1;
            scs_n_oe_o <= 1'b0;
        end
        else
        begin
            sck_oe_o   <= is_master;
            scs_n_oe_o <= is_master & select_pin_enable;
            sdo_oe_o   <= is_master | s_act;
            if (!busy_reg)
            begin
                scs_n_o <= 1'b1;
            end
            else if (half_tick)
            begin
                scs_n_o <= 1'b0;
            end
            if (!busy_reg)
            begin
                sck_o <= idle_level;
            end
            else if (m_edge)
            begin
                sck_o <= ~sck_o;
            end
            if (wr_ok)
            begin
                sdo_o <= out_bit(wd, bit_order_sel);
            end
            else if (!busy_any)
            begin
                sdo_o <= out_bit(data_reg, bit_order_sel);
            end
            else if (shf)
            begin
                sdo_o <= out_bit(data_reg, bit_order_sel);
            end
        end
    end

endmodule : spi_master_slave_port

// *** rtl/spi_pkg.sv ***
// Constants shared by the serial port design files.
package spi_pkg;

    localparam logic [4:0] OFF_MODE_CTRL  = 5'h00;
    localparam logic [4:0] OFF_FORMAT     = 5'h04;
    localparam logic [4:0] OFF_DATA       = 5'h08;
    localparam logic [4:0] OFF_INT_STATUS = 5'h0c;
    localparam logic [4:0] OFF_INT_MASK   = 5'h10;

    localparam logic [7:0] MODE_CTRL_RESET = 8'he0;
    localparam logic [7:0] FORMAT_RESET    = 8'h00;
    localparam logic [7:0] DATA_RESET      = 8'h00;

    localparam int MODE_MSB  = 7;
    localparam int MODE_LSB  = 5;
    localparam int DEB_MSB   = 3;
    localparam int DEB_LSB   = 2;
    localparam int EN_BIT    = 1;
    localparam int ICF_BIT   = 0;

    localparam int SPARE_MSB = 7;
    localparam int SPARE_LSB = 6;
    localparam int POL_BIT   = 5;
    localparam int EDGE_BIT  = 4;
    localparam int ORDER_BIT = 3;
    localparam int SELECT_PIN_ENABLE_BIT  = 2;
    localparam int WRITE_COLLISION_FLAG_BIT  = 1;
    localparam int TRF_BIT   = 0;

    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG_BIT = 1;
    localparam int IRQ_ICF_BIT  = 2;

    localparam logic [2:0] MODE_M_DIV4  = 3'h0;
    localparam logic [2:0] MODE_M_DIV16 = 3'h1;
    localparam logic [2:0] MODE_M_DIV64 = 3'h2;
    localparam logic [2:0] MODE_M_SUB   = 3'h3;
    localparam logic [2:0] MODE_M_TMR   = 3'h4;
    localparam logic [2:0] MODE_SLAVE   = 3'h5;
    localparam logic [2:0] MODE_I2C     = 3'h6;

    localparam logic [4:0] HALF_DIV4  = 5'h01;
    localparam logic [4:0] HALF_DIV16 = 5'h07;
    localparam logic [4:0] HALF_DIV64 = 5'h1f;

    localparam logic [4:0] MASTER_LAST_EDGE = 5'h0f;
    localparam logic [3:0] SLAVE_LAST_BIT   = 4'h7;

    typedef enum logic [1:0] {PORT_OFF, PORT_MASTER, PORT_SLAVE} port_role_t;

endpackage : spi_pkg

// *** rtl/pin_sync3.sv ***
// Three-stage input synchroniser whose output follows once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] stable_o
);

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    s1_reg      <= INIT[g];
                    s2_reg      <= INIT[g];
                    s3_reg      <= INIT[g];
                    stable_o[g] <= INIT[g];
                end
                else
                begin
                    s1_reg <= pin_i[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg)
                    begin
                        stable_o[g] <= s3_reg;
                    end
                end
            end
        end
    endgenerate

endmodule : pin_sync3

// *** test/spi_port_assertions.sv ***
// Concurrent checks on the serial port's pins and register bus.
`timescale 1ns/1ps
module spi_port_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [31:0]       dat_i,
    input wire logic [31:0]       dat_o,
    input wire logic              we_i,
    input wire logic [3:0]        sel_i,
    input wire logic              stb_i,
    input wire logic              cyc_i,
    input wire logic              ack_o,
    input wire logic              sck_i,
    input wire logic              sck_o,
    input wire logic              sck_oe_o,
    input wire logic              sdi_i,
    input wire logic              sdo_o,
    input wire logic              sdo_oe_o,
    input wire logic              scs_n_i,
    input wire logic              scs_n_o,
    input wire logic              scs_n_oe_o,
    input wire logic              sub_clk_i,
    input wire logic              tmr_match_i,
    input wire logic              irq_o
);
    logic [4:0] edge_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Counts clock toggles while the select output is low.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || scs_n_o)
            edge_cnt <= 5'h00;
        else if ($changed(sck_o))
            edge_cnt <= edge_cnt + 5'h01;
    end
    chk_ack_follows: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("ack missing after request");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
        else $error("ack without request");
    chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_select_role: assert property (scs_n_oe_o |-> sck_oe_o)
        else $error("select driven outside master role");
    chk_sck_quiet: assert property (($changed(sck_o) && sck_oe_o && $past(sck_oe_o)
        && $past(sck_oe_o, 2)) |-> !$past(scs_n_o))
        else $error("clock moved outside a transfer");
    chk_eight_bits: assert property ($rose(scs_n_o) |-> edge_cnt == 5'h10)
        else $error("transfer did not hold sixteen clock edges");
    chk_sdo_launch: assert property ((!scs_n_o && !$past(scs_n_o) && $changed(sdo_o))
        |-> ($changed(sck_o) || $past(sck_o) != $past(sck_o, 2)))
        else $error("data changed away from a clock edge");
    cov_xfer_end: cover property ($rose(scs_n_o));
    cov_irq: cover property ($rose(irq_o));
    cov_write: cover property (ack_o && we_i);
endmodule : spi_port_checker

// *** test/spi_peer_model.sv ***
// Behavioural SPI peripheral that answers the port while it acts as master.
`timescale 1ns/1ps
module spi_peer_model (
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic       mosi_i,
    input  wire logic       cap_rise_i,
    input  wire logic       msb_first_i,
    input  wire logic [7:0] reply_i,
    output logic            miso_o,
    output logic      [7:0] got_o
);
    logic [7:0] tx;
    logic [3:0] n;
    initial
    begin
        miso_o = 1'b0;
        got_o = 8'h00;
        tx = 8'h00;
        n = 4'h0;
    end
    // The single select line loads the reply byte.
    always @(negedge cs_n_i)
    begin
        tx = reply_i;
        n = 4'h0;
        miso_o = msb_first_i ? tx[7] : tx[0];
    end
    // A released data line does not keep its last level.
    always @(posedge cs_n_i) miso_o = ~miso_o;
    // Captures on the chosen edge, shifts on the other, never drives the clock.
    always @(sck_i)
    begin
        if (!cs_n_i && sck_i == cap_rise_i)
        begin
            got_o = msb_first_i ? {got_o[6:0], mosi_i} : {mosi_i, got_o[7:1]};
            n = n + 4'h1;
        end
        else if (!cs_n_i && n != 4'h0)
        begin
            tx = msb_first_i ? tx << 1 : tx >> 1;
            miso_o = msb_first_i ? tx[7] : tx[0];
        end
    end
endmodule : spi_peer_model

// *** test/spi_master_slave_port_tb.sv ***
// Self-checking bench for the serial port: register bus, master and slave transfers.
`timescale 1ns/1ps
module spi_master_slave_port_tb
    import spi_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        we_i = 1'b0;
    logic [3:0]  sel_i = 4'h0;
    logic        stb_i = 1'b0;
    logic        cyc_i = 1'b0;
    logic        ack_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, scs_n_o, scs_n_oe_o, irq_o, miso;
    logic        sck_i = 1'b1, sdi_b = 1'b0, scs_n_i = 1'b1, sub_clk_i = 1'b0;
    logic        tmr_match_i = 1'b0, slv = 1'b0, cap_rise = 1'b1, msb = 1'b1;
    logic [7:0]  peer_tx = 8'h00, peer_rx;
    logic [7:0]  fmt [5] = '{8'h1c, 8'h34, 8'h04, 8'h2c, 8'h14};
    wire logic   sdi_i = slv ? sdi_b : miso;
    int          fail_count = 0, compares = 0;
    // Pins are wired straight to the peer as if already routed to the port.
    spi_master_slave_port #(.ADDR_W(8)) i_spi_master_slave_port (.*);
    spi_peer_model i_spi_peer_model (.sck_i(sck_o), .cs_n_i(scs_n_o), .mosi_i(sdo_o),
        .cap_rise_i(cap_rise), .msb_first_i(msb), .reply_i(peer_tx), .miso_o(miso),
        .got_o(peer_rx));
    initial forever #20 clk_i = ~clk_i;
    initial forever
    begin
        repeat (8) @(posedge clk_i);
        sub_clk_i <= ~sub_clk_i;
        tmr_match_i <= 1'b1;
        @(posedge clk_i);
        tmr_match_i <= 1'b0;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
        @(posedge clk_i);
        adr_i <= {3'h0, a};
        we_i <= w;
        dat_i <= {24'h0, d};
        sel_i <= 4'h1;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input string what, input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] q;
        wb(a, 1'b0, 8'h00, q);
        check(what, exp, q);
    endtask : rd
    task automatic test_reset();
        rd("mode reset", OFF_MODE_CTRL, 8'he0);
        rd("format reset", OFF_FORMAT, 8'h00);
        wr(OFF_FORMAT, 8'hc0);
        rd("spare bits", OFF_FORMAT, 8'hc0);
        wr(5'h14, 8'hff);
        rd("unmapped", 5'h14, 8'h00);
        $display("test reset done");
    endtask : test_reset
    task automatic test_master(input int i);
        logic [7:0] f, tx, q;
        int n;
        f = fmt[i];
        tx = 8'h96 ^ 8'(i * 37);
        peer_tx = 8'h4b ^ 8'(i * 19);
        cap_rise = (f[5] == f[4]);
        msb = f[3];
        wr(OFF_MODE_CTRL, 8'he0);
        wr(OFF_FORMAT, f);
        wr(OFF_INT_STATUS, 8'h07);
        wr(OFF_INT_MASK, {7'h0, i[0]});
        wr(OFF_MODE_CTRL, {i[2:0], 5'h02});
        wr(OFF_DATA, tx);
        wr(OFF_DATA, 8'hff);
        rd("collision", OFF_FORMAT, f | 8'h02);
        n = 0;
        q = 8'h00;
        while (q[0] !== 1'b1 && n < 400)
        begin
            wb(OFF_FORMAT, 1'b0, 8'h00, q);
            n++;
        end
        check("done flag", f | 8'h03, q);
        rd("status", OFF_INT_STATUS, 8'h03);
        check("irq level", {7'h0, i[0]}, {7'h0, irq_o});
        check("peer got", tx, peer_rx);
        check("sck idle", {7'h0, ~f[5]}, {7'h0, sck_o});
        if (i != 0)
            rd("received", OFF_DATA, peer_tx);
        wr(OFF_INT_STATUS, 8'h07);
        repeat (2) @(posedge clk_i);
        check("irq cleared", 8'h00, {7'h0, irq_o});
        $display("test master %0d done", i);
    endtask : test_master
    task automatic test_keep();
        wr(OFF_FORMAT, 8'h08);
        wr(OFF_MODE_CTRL, 8'h22);
        repeat (2) @(posedge clk_i);
        check("select floats", 8'h00, {7'h0, scs_n_oe_o});
        wr(OFF_FORMAT, 8'h0c);
        repeat (2) @(posedge clk_i);
        check("select drives", 8'h01, {7'h0, scs_n_oe_o});
        wr(OFF_MODE_CTRL, 8'h20);
        rd("mode kept", OFF_MODE_CTRL, 8'h20);
        rd("format kept", OFF_FORMAT, 8'h0c);
        wr(OFF_DATA, 8'h55);
        repeat (4) @(posedge clk_i);
        check("no start off", 8'h01, {7'h0, scs_n_o});
        wr(OFF_MODE_CTRL, 8'hc2);
        repeat (2) @(posedge clk_i);
        check("other mode", 8'h00, {6'h0, sck_oe_o, sdo_oe_o});
        $display("test keep done");
    endtask : test_keep
    task automatic test_slave(input int nb, input logic [7:0] din);
        logic [7:0] got, d;
        got = 8'h00;
        d = din;
        slv <= 1'b1;
        wr(OFF_MODE_CTRL, 8'he0);
        wr(OFF_FORMAT, 8'h1c);
        wr(OFF_MODE_CTRL, 8'ha2);
        wr(OFF_DATA, 8'h5a);
        scs_n_i <= 1'b0;
        sdi_b <= d[7];
        repeat (8) @(posedge clk_i);
        for (int k = 0; k < nb; k++)
        begin
            sck_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            got = {got[6:0], sdo_o};
            d = d << 1;
            sck_i <= 1'b1;
            sdi_b <= d[7];
            repeat (4) @(posedge clk_i);
        end
        check("slave drives", 8'h01, {7'h0, sdo_oe_o});
        check("slave no clock", 8'h00, {7'h0, sck_oe_o});
        scs_n_i <= 1'b1;
        sdi_b <= ~sdi_b;
        repeat (8) @(posedge clk_i);
        if (nb == 8)
        begin
            check("slave sent", 8'h5a, got);
            rd("slave got", OFF_DATA, din);
            rd("slave done", OFF_FORMAT, 8'h1d);
        end
        else
            rd("incomplete", OFF_MODE_CTRL, 8'ha3);
        slv <= 1'b0;
        $display("test slave %0d done", nb);
    endtask : test_slave
    task automatic tally_and_finish();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        for (int i = 0; i < 5; i++)
            test_master(i);
        test_keep();
        test_slave(8, 8'hc3);
        test_slave(3, 8'h81);
        tally_and_finish();
    end
    initial
    begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end
endmodule : spi_master_slave_port_tb
bind spi_master_slave_port spi_port_checker #(.ADDR_W(ADDR_W)) i_spi_port_checker (.*);
